// >>> design/rwcg_chip_buffer.sv
`timescale 1ns/1ps
`default_nettype none

// Shifting FIFO: entry 0 is always the head, so outputs come from flops
module rwcg_chip_buffer #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);

   logic [WIDTH-1:0] entry_q [DEPTH];
   logic [WIDTH-1:0] entry_d [DEPTH];
   logic [DEPTH-1:0] full_q;
   logic [DEPTH-1:0] full_d;
   logic             push;
   logic             pop;

   // Handshakes; full when the last entry holds a word
   assign inReady  = ~full_q[DEPTH-1];
   assign push     = inValid & inReady;
   assign pop      = full_q[0] & outReady;
   assign outValid = full_q[0];
   assign outData  = entry_q[0];

   // ****************************************************************
   // Per-entry next value and storage
   // ****************************************************************
   for (genvar i = 0; i < DEPTH; i++) begin : gEntry
      logic [WIDTH-1:0] upper;
      logic             upperFull;
      logic             lowerFull;

      if (i == DEPTH - 1) begin : gTop
         assign upper     = '0;
         assign upperFull = 1'b0;
      end else begin : gMid
         assign upper     = entry_q[i+1];
         assign upperFull = full_q[i+1];
      end
      if (i == 0) begin : gBot
         assign lowerFull = 1'b1;
      end else begin : gLow
         assign lowerFull = full_q[i-1];
      end

      // Shift down on pop, write into the first free slot on push
      always_comb begin
         entry_d[i] = entry_q[i];
         full_d[i]  = full_q[i];
         if (pop) begin
            entry_d[i] = upper;
            full_d[i]  = upperFull;
            if (push && full_q[i] && !upperFull) begin
               entry_d[i] = inData;
               full_d[i]  = 1'b1;
            end
         end else if (push && !full_q[i] && lowerFull) begin
            entry_d[i] = inData;
            full_d[i]  = 1'b1;
         end
      end

      // Entry registers
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            entry_q[i] <= '0;
            full_q[i]  <= 1'b0;
         end else begin
            entry_q[i] <= entry_d[i];
            full_q[i]  <= full_d[i];
         end
      end
   end

endmodule : rwcg_chip_buffer

`default_nettype wire

// >>> design/rwcg_consts.svh
`ifndef RWCG_CONSTS_SVH
`define RWCG_CONSTS_SVH

// ****************************************************************
// Frame and code geometry
// ****************************************************************
`define RWCG_SYMBOLS_PER_FRAME 68
`define RWCG_SYMBOL_CNT_W      7
`define RWCG_CODE_LEN          65535
`define RWCG_CHIP_CNT_W        16

// ****************************************************************
// Identity and shift register layout
// ****************************************************************
`define RWCG_ID_W        24
`define RWCG_LONG_W      16
`define RWCG_SHORT_W     8
`define RWCG_SHORT_LSB   0
`define RWCG_THIRD_LSB   8

// ****************************************************************
// Feedback masks (Galois form, plain defaults)
// ****************************************************************
`define RWCG_LONG_TAPS   16'hB400
`define RWCG_SHORT_TAPS  8'hB8
`define RWCG_THIRD_TAPS  16'hD008

// ****************************************************************
// Preload values
// ****************************************************************
`define RWCG_LONG_SEED   16'h0001
`define RWCG_SYNC_SHORT  8'h01
`define RWCG_SYNC_THIRD  16'h0001
`define RWCG_FIXED_ID    24'h00_0001  // Arbitrary hardware identity

// ****************************************************************
// Output buffer
// ****************************************************************
`define RWCG_BUF_DEPTH   2
`define RWCG_BUF_WIDTH   2

`endif

// >>> design/rwcg_pkg.sv
// ****************************************************************
// Types shared by the watermark generator
// ****************************************************************
package rwcg_pkg;

   typedef enum logic [1:0] {
      GEN_IDLE  = 2'b00,
      GEN_SYNC  = 2'b01,
      GEN_IDENT = 2'b10
   } rwcg_state_type;

endpackage : rwcg_pkg

// >>> design/rwcg_watermark_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "rwcg_consts.svh"

module rwcg_watermark_gen #(
   parameter int               CODE_LEN      = `RWCG_CODE_LEN,
   parameter int               SYMS_PER_FRM  = `RWCG_SYMBOLS_PER_FRAME,
   parameter logic [15:0]      LONG_TAPS     = `RWCG_LONG_TAPS,
   parameter logic [7:0]       SHORT_TAPS    = `RWCG_SHORT_TAPS,
   parameter logic [15:0]      THIRD_TAPS    = `RWCG_THIRD_TAPS,
   parameter logic [23:0]      FIXED_ID      = `RWCG_FIXED_ID
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   // Host frame timing
   input  wire logic                   sampleTick,
   input  wire logic                   symbolStart,
   input  wire logic                   frameStart,
   // Identity configuration
   input  wire logic [`RWCG_ID_W-1:0]  userIdentity,
   input  wire logic                   useFixedIdentity,
   // Serial data option
   input  wire logic                   modEnable,
   input  wire logic                   dataBit,
   input  wire logic                   dataValid,
   output logic                        dataAck,
   // Chip stream to the embedder
   output logic                        chipValid,
   input  wire logic                   chipReady,
   output logic                        chipBit,
   output logic                        chipFrameStart,
   // Status
   output logic                        inSyncSequence
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   rwcg_pkg::rwcg_state_type           state_q;
   rwcg_pkg::rwcg_state_type           state_d;
   logic [`RWCG_LONG_W-1:0]            longReg_q;
   logic [`RWCG_LONG_W-1:0]            longReg_d;
   logic [`RWCG_SHORT_W-1:0]           shortReg_q;
   logic [`RWCG_SHORT_W-1:0]           shortReg_d;
   logic [`RWCG_LONG_W-1:0]            thirdReg_q;
   logic [`RWCG_LONG_W-1:0]            thirdReg_d;
   logic [`RWCG_CHIP_CNT_W-1:0]        chipCnt_q;
   logic [`RWCG_CHIP_CNT_W-1:0]        chipCnt_d;
   logic [`RWCG_SYMBOL_CNT_W-1:0]      symCnt_q;
   logic [`RWCG_SYMBOL_CNT_W-1:0]      symCnt_d;
   logic [`RWCG_ID_W-1:0]              identity_q;
   logic [`RWCG_ID_W-1:0]              identity_d;
   logic                               modBit_q;
   logic                               modBit_d;
   logic                               dataAck_q;
   logic                               dataAck_d;
   logic                               firstChip_q;
   logic                               firstChip_d;
   logic                               inSync_q;
   logic                               restart;
   logic                               step;
   logic                               lastChip;
   logic                               bufReady;
   logic                               pushChip;
   logic                               bufValid;
   logic [`RWCG_BUF_WIDTH-1:0]         bufOut;
   logic                               chip;
   logic [`RWCG_ID_W-1:0]              activeId;
   logic [`RWCG_SHORT_W-1:0]           idShort;
   logic [`RWCG_LONG_W-1:0]            idThird;
   logic [15:0]                        shortStep;

   localparam logic [`RWCG_SYMBOL_CNT_W-1:0] SymLast =
      `RWCG_SYMBOL_CNT_W'(SYMS_PER_FRM - 1);
   localparam logic [`RWCG_CHIP_CNT_W-1:0]   ChipLast =
      `RWCG_CHIP_CNT_W'(CODE_LEN - 1);

   // Galois step of one shift register
   function automatic logic [15:0] lfsrStep(input logic [15:0] val, input logic [15:0] taps);
      lfsrStep = val[0] ? ((val >> 1) ^ taps) : (val >> 1);
   endfunction : lfsrStep

   // ****************************************************************
   // Frame timing
   // ****************************************************************

   // Restart on host frame start or after the last symbol of the frame
   assign restart = frameStart | (symbolStart & (symCnt_q == SymLast));

   // Symbol counter, realigned on every host frame start
   always_comb begin
      symCnt_d = symCnt_q;
      if (restart) begin
         symCnt_d = '0;
      end else if (symbolStart) begin
         symCnt_d = symCnt_q + `RWCG_SYMBOL_CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         symCnt_q <= '0;
      end else begin
         symCnt_q <= symCnt_d;
      end
   end

   // ****************************************************************
   // Identity selection and preload encoding
   // ****************************************************************

   // Fixed hardware identity or user value, captured at each restart
   assign activeId = useFixedIdentity ? FIXED_ID : userIdentity;
   assign idShort  = identity_q[`RWCG_SHORT_LSB +: `RWCG_SHORT_W];
   assign idThird  = identity_q[`RWCG_THIRD_LSB +: `RWCG_LONG_W];

   // ****************************************************************
   // Code generator
   // ****************************************************************

   // Advance one chip per host sample, held while the buffer is full
   assign step     = sampleTick & bufReady & (state_q != rwcg_pkg::GEN_IDLE);
   assign lastChip = (chipCnt_q == ChipLast);
   assign chip     = longReg_q[0] ^ shortReg_q[0] ^ thirdReg_q[0]
                     ^ (modEnable & modBit_q);
   assign pushChip = step & ~restart;

   // Short register stepped in a widened copy; only the low byte is kept
   assign shortStep = lfsrStep({8'h00, shortReg_q}, {8'h00, SHORT_TAPS});

   // Next state of the three registers, chip counter and sequence phase
   always_comb begin
      state_d     = state_q;
      longReg_d   = longReg_q;
      shortReg_d  = shortReg_q;
      thirdReg_d  = thirdReg_q;
      chipCnt_d   = chipCnt_q;
      identity_d  = identity_q;
      firstChip_d = firstChip_q;
      modBit_d    = modBit_q;
      dataAck_d   = 1'b0;
      if (restart) begin
         // Cut the running code short and reload the sync sequence
         state_d     = rwcg_pkg::GEN_SYNC;
         longReg_d   = `RWCG_LONG_SEED;
         shortReg_d  = `RWCG_SYNC_SHORT;
         thirdReg_d  = `RWCG_SYNC_THIRD;
         chipCnt_d   = '0;
         identity_d  = activeId;
         firstChip_d = 1'b1;
         if (dataValid) begin
            modBit_d  = dataBit;
            dataAck_d = 1'b1;
         end
      end else if (step) begin
         firstChip_d = 1'b0;
         if (lastChip) begin
            // Period done: reload with the identity preload and repeat
            state_d    = rwcg_pkg::GEN_IDENT;
            longReg_d  = `RWCG_LONG_SEED;
            shortReg_d = (idShort == '0) ? `RWCG_SYNC_SHORT : idShort;
            thirdReg_d = (idThird == '0) ? `RWCG_SYNC_THIRD : idThird;
            chipCnt_d  = '0;
         end else begin
            longReg_d  = lfsrStep(longReg_q, LONG_TAPS);
            shortReg_d = shortStep[`RWCG_SHORT_W-1:0];
            thirdReg_d = lfsrStep(thirdReg_q, THIRD_TAPS);
            chipCnt_d  = chipCnt_q + `RWCG_CHIP_CNT_W'(1);
         end
      end
   end

   // Generator registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q     <= rwcg_pkg::GEN_IDLE;
         longReg_q   <= `RWCG_LONG_SEED;
         shortReg_q  <= `RWCG_SYNC_SHORT;
         thirdReg_q  <= `RWCG_SYNC_THIRD;
         chipCnt_q   <= '0;
         identity_q  <= '0;
         firstChip_q <= 1'b0;
         modBit_q    <= 1'b0;
         dataAck_q   <= 1'b0;
         inSync_q    <= 1'b0;
      end else begin
         state_q     <= state_d;
         longReg_q   <= longReg_d;
         shortReg_q  <= shortReg_d;
         thirdReg_q  <= thirdReg_d;
         chipCnt_q   <= chipCnt_d;
         identity_q  <= identity_d;
         firstChip_q <= firstChip_d;
         modBit_q    <= modBit_d;
         dataAck_q   <= dataAck_d;
         inSync_q    <= (state_d == rwcg_pkg::GEN_SYNC);
      end
   end

   // ****************************************************************
   // Output buffer and ports
   // ****************************************************************

   // Two-entry buffer between generator and embedder
   rwcg_chip_buffer #(
      .WIDTH (`RWCG_BUF_WIDTH),
      .DEPTH (`RWCG_BUF_DEPTH)
   ) uBuffer (
      .clk      (clk),
      .reset_n  (reset_n),
      .inValid  (pushChip),
      .inReady  (bufReady),
      .inData   ({firstChip_q, chip}),
      .outValid (bufValid),
      .outReady (chipReady),
      .outData  (bufOut)
   );

   // Ports straight from flops
   assign chipValid      = bufValid;
   assign chipBit        = bufOut[0];
   assign chipFrameStart = bufOut[1];
   assign dataAck        = dataAck_q;
   assign inSyncSequence = inSync_q;

endmodule : rwcg_watermark_gen

`default_nettype wire

// >>> tb/rwcg_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Host modulator sample strobes and embedder acceptance
// ****************************************************************
module rwcg_host_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Control from the bench
   input  wire logic run,
   input  wire logic stall,
   // Toward the generator
   output logic      sampleTick,
   output logic      chipReady
);
   // Random strobes and stalls, moved just after each rising edge
   initial begin
      sampleTick = 1'b0;
      chipReady  = 1'b0;
      forever begin
         @(posedge clk);
         #1;
         sampleTick = run && reset_n && ($urandom_range(1, 0) == 1);
         chipReady  = !stall && ($urandom_range(3, 0) != 0);
      end
   end
endmodule : rwcg_host_model

`default_nettype wire

// >>> tb/rwcg_watermark_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Checker of the chip stream and control outputs
// ****************************************************************
module rwcg_watermark_monitor (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Timing and data
   input  wire logic sampleTick,
   input  wire logic symbolStart,
   input  wire logic frameStart,
   input  wire logic dataValid,
   input  wire logic dataAck,
   // Chip stream and status
   input  wire logic chipValid,
   input  wire logic chipReady,
   input  wire logic chipBit,
   input  wire logic chipFrameStart,
   input  wire logic inSyncSequence
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Stalled head chip keeps its value and flag
   a_head_held_stall: assert property (
      chipValid && !chipReady |=> chipValid && $stable({chipBit, chipFrameStart}))
      else $error("head chip changed while stalled");
   // Data bit taken at restart is acknowledged next cycle
   a_ack_on_take: assert property (
      frameStart && dataValid |=> dataAck)
      else $error("data bit not acknowledged");
   // Acknowledge only follows a restart with valid data
   a_ack_has_cause: assert property (
      dataAck |-> $past(frameStart || symbolStart) && $past(dataValid))
      else $error("acknowledge without restart");
   // Every host frame start begins the sync sequence
   a_sync_after_restart: assert property (
      frameStart |=> inSyncSequence)
      else $error("sync sequence not started");
   // Sync period ends only on a chip step
   a_sync_end_step: assert property (
      $fell(inSyncSequence) |-> $past(sampleTick))
      else $error("sync period ended without a step");
   // First chip after restart carries the frame flag
   a_first_chip_flag: assert property (
      frameStart ##1 (sampleTick && !chipValid && !frameStart && !symbolStart)
      |=> chipValid && chipFrameStart)
      else $error("first chip lacks frame flag");
   // One sample step yields a chip one cycle later
   a_tick_to_chip: assert property (
      sampleTick && !chipValid && inSyncSequence && !frameStart && !symbolStart
      |=> chipValid)
      else $error("sample step made no chip");
   // No chip appears without a sample step
   a_no_tick_idle: assert property (
      !chipValid && !sampleTick |=> !chipValid)
      else $error("chip without sample step");
   // Outputs are quiet at the first edge after reset
   a_reset_quiet: assert property (
      $rose(reset_n) |-> !chipValid && !dataAck && !inSyncSequence)
      else $error("outputs active after reset");
endmodule : rwcg_watermark_monitor

bind rwcg_watermark_gen rwcg_watermark_monitor u_mon (
   .clk(clk), .reset_n(reset_n), .sampleTick(sampleTick), .symbolStart(symbolStart),
   .frameStart(frameStart), .dataValid(dataValid), .dataAck(dataAck),
   .chipValid(chipValid), .chipReady(chipReady), .chipBit(chipBit),
   .chipFrameStart(chipFrameStart), .inSyncSequence(inSyncSequence));

`default_nettype wire

// >>> tb/test_rf_watermark_code_generator.sv
`timescale 1ns/1ps
`default_nettype none
`include "rwcg_consts.svh"

module test_rf_watermark_code_generator;
   localparam int LEN = 15;
   logic        clk, reset_n, run, stall, sampleTick, symbolStart, frameStart;
   logic [23:0] userIdentity;
   logic        useFixedIdentity, modEnable, dataBit, dataValid, heldBit;
   logic        dataAck, chipValid, chipReady, chipBit, chipFrameStart, inSyncSequence;
   int          error_cnt, cmp_count, ackCnt, ackBase;
   logic [1:0]  got[$];

   // ****************************************************************
   // Clock, partner and design
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   rwcg_host_model host (.clk(clk), .reset_n(reset_n), .run(run), .stall(stall),
      .sampleTick(sampleTick), .chipReady(chipReady));

   rwcg_watermark_gen #(.CODE_LEN(LEN)) dut (.clk(clk), .reset_n(reset_n),
      .sampleTick(sampleTick), .symbolStart(symbolStart), .frameStart(frameStart),
      .userIdentity(userIdentity), .useFixedIdentity(useFixedIdentity),
      .modEnable(modEnable), .dataBit(dataBit), .dataValid(dataValid), .dataAck(dataAck),
      .chipValid(chipValid), .chipReady(chipReady), .chipBit(chipBit),
      .chipFrameStart(chipFrameStart), .inSyncSequence(inSyncSequence));

   // Collects accepted chips and counts acknowledges
   always @(posedge clk) begin
      if (chipValid === 1'b1 && chipReady === 1'b1) got.push_back({chipFrameStart, chipBit});
      if (dataAck === 1'b1) ackCnt++;
   end

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [15:0] gal(logic [15:0] s, logic [15:0] m);
      return s[0] ? ((s >> 1) ^ m) : (s >> 1);
   endfunction : gal

   task automatic cyc();
      @(posedge clk);
      #1;
   endtask : cyc

   task automatic check(logic [1:0] seen, logic [1:0] want);
      cmp_count++;
      if (seen !== want) begin
         error_cnt++;
         $display("MISMATCH at %0t: seen %b want %b", $time, seen, want);
      end
   endtask : check

   task automatic give_verdict();
      $display("mismatches %0d, comparisons %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict

   // One restart, n chips with stalls, then compare against the reference
   task automatic frame(logic [23:0] id, logic fix, logic md, logic bv, logic dv, int n);
      logic [15:0] l, h, t;
      logic [23:0] xid;
      xid = fix ? `RWCG_FIXED_ID : id;
      if (dv) heldBit = bv;
      userIdentity = id;
      useFixedIdentity = fix;
      modEnable = md;
      dataBit = bv;
      dataValid = dv;
      ackBase = ackCnt;
      got.delete();
      frameStart = 1'b1;
      cyc();
      frameStart = 1'b0;
      userIdentity = ~id;
      run = 1'b1;
      for (int i = 0; i < 4000 && got.size() < n; i++) begin
         stall = (i % 40) < 20;
         cyc();
      end
      run = 1'b0;
      stall = 1'b0;
      repeat (12) cyc();
      check(2'(ackCnt - ackBase), {1'b0, dv});
      check({1'b0, got.size() >= n}, 2'b01);
      for (int k = 0; k < n; k++) begin
         if (k % LEN == 0) begin
            l = `RWCG_LONG_SEED;
            h = (k == 0 || xid[7:0] == 0) ? 16'(`RWCG_SYNC_SHORT) : 16'(xid[7:0]);
            t = (k == 0 || xid[23:8] == 0) ? `RWCG_SYNC_THIRD : xid[23:8];
         end
         check(got[k], {k == 0, l[0] ^ h[0] ^ t[0] ^ (md & heldBit)});
         l = gal(l, `RWCG_LONG_TAPS);
         h = gal(h, 16'(`RWCG_SHORT_TAPS));
         t = gal(t, `RWCG_THIRD_TAPS);
      end
   endtask : frame

   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   initial begin
      {run, stall, symbolStart, frameStart, useFixedIdentity} = '0;
      {modEnable, dataBit, dataValid, heldBit} = '0;
      userIdentity = 24'h00_0000;
      {error_cnt, cmp_count, ackCnt, ackBase} = '0;
      reset_n = 1'b0;
      void'($urandom(21));
      repeat (10) @(posedge clk);
      #1;
      reset_n = 1'b1;
      cyc();
      frame(24'h5A_3C96, 1'b0, 1'b1, 1'b1, 1'b1, 3 * LEN);
      frame(24'h00_0000, 1'b0, 1'b1, 1'b0, 1'b0, 2 * LEN);
      frame(24'h12_3400, 1'b1, 1'b0, 1'b1, 1'b1, 2 * LEN);
      for (int r = 0; r < 5; r++) begin
         frame(24'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 2 * LEN);
      end
      dataValid = 1'b0;
      frameStart = 1'b1;
      cyc();
      frameStart = 1'b0;
      dataValid = 1'b1;
      ackBase = ackCnt;
      for (int i = 0; i < `RWCG_SYMBOLS_PER_FRAME; i++) begin
         if (i == `RWCG_SYMBOLS_PER_FRAME - 1) check(2'(ackCnt - ackBase), 2'b00);
         symbolStart = 1'b1;
         cyc();
         symbolStart = 1'b0;
         cyc();
      end
      check(2'(ackCnt - ackBase), 2'b01);
      give_verdict();
   end

   // Cuts a hang short well beyond the expected run length
   initial begin
      #80000;
      error_cnt++;
      give_verdict();
   end
endmodule : test_rf_watermark_code_generator

`default_nettype wire
